// ==== common/itc_pkg.sv ====
/*
 * Constants for the interrupt pin and tilt threshold configuration block:
 * register addresses, field positions, reset values and detector encodings.
 * Assumes an 8-bit register address and an 8-bit data path.
 */
package itc_pkg;
    localparam logic [7:0] ADDR_INTR_STATUS      = 8'h14;
    localparam logic [7:0] ADDR_COMM_CONTROL     = 8'h31;
    localparam logic [7:0] ADDR_INTR_PIN_CONTROL = 8'h33;
    localparam logic [7:0] ADDR_TILT_THRESH_LOW  = 8'h40;
    localparam logic [7:0] ADDR_TILT_THRESH_HIGH = 8'h41;

    localparam logic [7:0] RST_COMM_CONTROL      = 8'h00;
    localparam logic [7:0] RST_INTR_PIN_CONTROL  = 8'h00;
    localparam logic [7:0] RST_TILT_THRESH_LOW   = 8'h00;
    localparam logic [7:0] RST_TILT_THRESH_HIGH  = 8'h00;
    localparam logic [7:0] RST_INTR_FLAGS        = 8'h00;

    // Communication control fields
    localparam int BIT_IRQ_PIN_SWAP          = 4;
    localparam int BIT_THREE_WIRE_ENABLE     = 5;
    localparam int BIT_BITMASK_CLEAR_ENABLE  = 6;
    // Bits that read back; 0,1 read zero, 2,3,7 kept as written
    localparam logic [7:0] COMM_READ_MASK    = 8'hfc;

    // Interrupt pin control fields
    localparam int BIT_PIN_A_ACTIVE_HIGH     = 2;
    localparam int BIT_PIN_A_PUSH_PULL       = 3;
    localparam int BIT_PIN_B_ACTIVE_HIGH     = 6;
    localparam int BIT_PIN_B_PUSH_PULL       = 7;

    // Interrupt status flag position of the tilt-35 event
    localparam int BIT_TILT35_FLAG           = 4;

    localparam int TILT_THRESHOLD_W          = 15;
    localparam int SAMPLE_W                  = 16;

    typedef enum logic [1:0] {
        ITC_POS_FLAT,
        ITC_POS_TILT,
        ITC_POS_FLIP
    } itc_position_e;
endpackage : itc_pkg

// ==== hw/itc_config.sv ====
/*
 * Interrupt pin routing and drive, serial three-wire data pin control,
 * interrupt flag clearing and the shared tilt/flip threshold with its
 * flat/tilt/flip and tilt-35 comparisons.
 * Assumes the serial register front end presents one-cycle read/write
 * strobes with an 8-bit address and data, synchronous to clk.
 * Pin B general-output mode and the Z inputs come from elsewhere in the device.
 */
`timescale 1ns/100ps
module itc_config (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // Register access from serial front end
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    output logic      [7:0]          reg_rdata,
    // Interrupt request sources and events
    input  wire logic                irq_source_a,
    input  wire logic                irq_source_b,
    input  wire logic [7:0]          intr_event,
    input  wire logic                pin_b_gpio_mode,
    // Tilt detection inputs
    input  wire logic                sample_valid,
    input  wire logic [15:0]         tilt_sample,
    input  wire logic                z_negative,
    input  wire logic                z_orient,
    // Detector results
    output logic [1:0]               position,
    output logic                     tilt35_detect,
    output logic [7:0]               intr_flags,
    // Interrupt pins, enable low while driving
    output logic                     irq_pin_a_o,
    output logic                     irq_pin_a_oe_n,
    output logic                     irq_pin_b_o,
    output logic                     irq_pin_b_oe_n,
    // Serial data pin direction and bitmask clear enable
    output logic                     serial_out_pin_bidir,
    output logic                     bitmask_clear_enable
);
    logic [7:0]  comm_control,        next_comm_control;
    logic [7:0]  intr_pin_control,    next_intr_pin_control;
    logic [7:0]  tilt_threshold_low,  next_tilt_threshold_low;
    logic [7:0]  tilt_threshold_high, next_tilt_threshold_high;
    logic [7:0]  next_intr_flags;
    logic [7:0]  next_reg_rdata;
    logic [1:0]  next_position;
    logic        next_tilt35_detect;
    logic        next_pin_a_o, next_pin_a_oe_n, next_pin_b_o, next_pin_b_oe_n;
    logic        req_a, req_b, b_level;
    logic [14:0] tilt_threshold;
    logic [15:0] sample_mag;
    logic        status_wr;
    logic [7:0]  flag_clear;

    assign tilt_threshold = {tilt_threshold_high[6:0], tilt_threshold_low};

    // Any write to the status address is a clear request
    assign status_wr = reg_wr && (reg_addr == itc_pkg::ADDR_INTR_STATUS);

    // Per-flag clear: every flag, or only those written as one
    for (genvar i = 0; i < 8; i++) begin : g_flag_clear
        assign flag_clear[i] = status_wr
            && (!comm_control[itc_pkg::BIT_BITMASK_CLEAR_ENABLE]
                || reg_wdata[i]);
    end

    // Configuration register writes
    always_comb begin
        next_comm_control        = comm_control;
        next_intr_pin_control    = intr_pin_control;
        next_tilt_threshold_low  = tilt_threshold_low;
        next_tilt_threshold_high = tilt_threshold_high;
        if (reg_wr) begin
            case (reg_addr)
                itc_pkg::ADDR_COMM_CONTROL:     next_comm_control = reg_wdata;
                itc_pkg::ADDR_INTR_PIN_CONTROL: next_intr_pin_control = reg_wdata;
                itc_pkg::ADDR_TILT_THRESH_LOW:  next_tilt_threshold_low = reg_wdata;
                itc_pkg::ADDR_TILT_THRESH_HIGH: next_tilt_threshold_high = reg_wdata;
                default: ;
            endcase
        end
    end

    // Interrupt flags; events set after clear so a same-cycle event survives
    always_comb begin
        next_intr_flags = (intr_flags & ~flag_clear) | intr_event;
        if (next_tilt35_detect)
            next_intr_flags[itc_pkg::BIT_TILT35_FLAG] = 1'b1;
    end

    // Read data
    always_comb begin
        next_reg_rdata = reg_rdata;
        if (reg_rd) begin
            case (reg_addr)
                itc_pkg::ADDR_COMM_CONTROL:
                    next_reg_rdata = comm_control & itc_pkg::COMM_READ_MASK;
                itc_pkg::ADDR_INTR_STATUS: next_reg_rdata = intr_flags;
                default:                   next_reg_rdata = 8'h00;
            endcase
        end
    end

    // Tilt detection
    always_comb begin
        sample_mag         = tilt_sample[15] ? 16'(-tilt_sample) : tilt_sample;
        next_position      = position;
        next_tilt35_detect = 1'b0;
        // Equal to threshold: position held, no tilt-35 event
        if (sample_valid) begin
            if (sample_mag > {1'b0, tilt_threshold}) begin
                next_position      = 2'(itc_pkg::ITC_POS_TILT);
                next_tilt35_detect = 1'b1;
            end else if (sample_mag < {1'b0, tilt_threshold}) begin
                next_position = (z_negative ^ z_orient) ? 2'(itc_pkg::ITC_POS_FLIP)
                                                        : 2'(itc_pkg::ITC_POS_FLAT);
            end
        end
    end

    // Pin routing and drive
    always_comb begin
        req_a = comm_control[itc_pkg::BIT_IRQ_PIN_SWAP] ? irq_source_b : irq_source_a;
        req_b = comm_control[itc_pkg::BIT_IRQ_PIN_SWAP] ? irq_source_a : irq_source_b;
        b_level = pin_b_gpio_mode ? 1'b1 : req_b;
        // Polarity: asserted level equals the active-high bit
        next_pin_a_o = req_a ~^ intr_pin_control[itc_pkg::BIT_PIN_A_ACTIVE_HIGH];
        next_pin_b_o = b_level ~^ intr_pin_control[itc_pkg::BIT_PIN_B_ACTIVE_HIGH];
        // Open-drain: enable follows level, so only a low is ever driven
        if (intr_pin_control[itc_pkg::BIT_PIN_A_PUSH_PULL])
            next_pin_a_oe_n = 1'b0;
        else
            next_pin_a_oe_n = next_pin_a_o;
        if (intr_pin_control[itc_pkg::BIT_PIN_B_PUSH_PULL])
            next_pin_b_oe_n = 1'b0;
        else
            next_pin_b_oe_n = next_pin_b_o;
    end

    // Configuration registers and their pin-facing copies
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            comm_control         <= itc_pkg::RST_COMM_CONTROL;
            intr_pin_control     <= itc_pkg::RST_INTR_PIN_CONTROL;
            tilt_threshold_low   <= itc_pkg::RST_TILT_THRESH_LOW;
            tilt_threshold_high  <= itc_pkg::RST_TILT_THRESH_HIGH;
            serial_out_pin_bidir <= 1'b0;
            bitmask_clear_enable <= 1'b0;
        end else begin
            comm_control         <= next_comm_control;
            intr_pin_control     <= next_intr_pin_control;
            tilt_threshold_low   <= next_tilt_threshold_low;
            tilt_threshold_high  <= next_tilt_threshold_high;
            serial_out_pin_bidir <= next_comm_control[itc_pkg::BIT_THREE_WIRE_ENABLE];
            bitmask_clear_enable <= next_comm_control[itc_pkg::BIT_BITMASK_CLEAR_ENABLE];
        end
    end

    // Sticky interrupt flags
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            intr_flags <= itc_pkg::RST_INTR_FLAGS;
        end else begin
            intr_flags <= next_intr_flags;
        end
    end

    // Read data holds until the next read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    // Detector results
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            position      <= 2'(itc_pkg::ITC_POS_FLAT);
            tilt35_detect <= 1'b0;
        end else begin
            position      <= next_position;
            tilt35_detect <= next_tilt35_detect;
        end
    end

    // Pin levels and drive enables, released during reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_pin_a_o    <= 1'b1;
            irq_pin_a_oe_n <= 1'b1;
            irq_pin_b_o    <= 1'b1;
            irq_pin_b_oe_n <= 1'b1;
        end else begin
            irq_pin_a_o    <= next_pin_a_o;
            irq_pin_a_oe_n <= next_pin_a_oe_n;
            irq_pin_b_o    <= next_pin_b_o;
            irq_pin_b_oe_n <= next_pin_b_oe_n;
        end
    end
endmodule : itc_config

// ==== sim/itc_config_assertions.sv ====
/* Port checker of itc_config with shadow copies of its registers.
   Assumes one clock and the bind below. */
`timescale 1ns/100ps
module itc_config_assertions (
    // Clock, reset and register bus
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    // Sources, detector and pins
    input wire logic        irq_source_a,
    input wire logic        irq_source_b,
    input wire logic [7:0]  intr_event,
    input wire logic        sample_valid,
    input wire logic [15:0] tilt_sample,
    input wire logic        z_negative,
    input wire logic        z_orient,
    input wire logic [1:0]  position,
    input wire logic        tilt35_detect,
    input wire logic [7:0]  intr_flags,
    input wire logic        irq_pin_a_o,
    input wire logic        irq_pin_a_oe_n,
    input wire logic        serial_out_pin_bidir
);
    logic [31:0] regs, next_regs;
    logic [15:0] mag, thr;
    logic        lvl;
    always_comb begin
        next_regs = regs;
        if (reg_wr && reg_addr == itc_pkg::ADDR_COMM_CONTROL) begin
            next_regs[31:24] = reg_wdata;
        end
        if (reg_wr && reg_addr == itc_pkg::ADDR_INTR_PIN_CONTROL) begin
            next_regs[23:16] = reg_wdata;
        end
        if (reg_wr && reg_addr == itc_pkg::ADDR_TILT_THRESH_HIGH) begin
            next_regs[15:8] = reg_wdata;
        end
        if (reg_wr && reg_addr == itc_pkg::ADDR_TILT_THRESH_LOW) begin
            next_regs[7:0] = reg_wdata;
        end
    end
    always_ff @(posedge clk) begin
        regs <= rst_n ? next_regs : 32'h0;
    end
    assign thr = {1'b0, regs[14:0]};
    assign mag = tilt_sample[15] ? 16'h0 - tilt_sample : tilt_sample;
    assign lvl = regs[18] ~^ (regs[28] ? irq_source_b : irq_source_a);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_stat_wr;
        reg_wr && reg_addr == itc_pkg::ADDR_INTR_STATUS && intr_event == 8'h00 && !sample_valid;
    endsequence
    a_pin_pushpull: assert property ($past(rst_n) && $past(regs[19]) |->
        !irq_pin_a_oe_n && irq_pin_a_o == $past(lvl)) else $error("pin A level wrong");
    a_pin_opendrain: assert property ($past(rst_n) && !$past(regs[19]) |->
        irq_pin_a_oe_n == $past(lvl)) else $error("pin A release wrong");
    a_bidir_follow: assert property ($changed(regs[29]) |-> ##[0:1]
        serial_out_pin_bidir == regs[29]) else $error("three-wire mode wrong");
    a_clear_all: assert property (s_stat_wr ##0 !regs[30] |=>
        intr_flags == 8'h00) else $error("flags not all cleared");
    a_clear_mask: assert property (s_stat_wr ##0 regs[30] |=>
        intr_flags == ($past(intr_flags) & ~$past(reg_wdata))) else $error("mask clear wrong");
    a_comm_read: assert property (reg_rd && reg_addr == itc_pkg::ADDR_COMM_CONTROL |=>
        reg_rdata == ($past(regs[31:24]) & 8'hfc)) else $error("control readback wrong");
    a_tilt_over: assert property (sample_valid && mag > thr |=>
        position == 2'h1 && tilt35_detect && intr_flags[4]) else $error("tilt missed");
    a_tilt_under: assert property (sample_valid && mag < thr |=> !tilt35_detect &&
        position == ($past(z_negative ^ z_orient) ? 2'h2 : 2'h0)) else $error("flat/flip wrong");
endmodule : itc_config_assertions
bind itc_config itc_config_assertions u_chk (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .irq_source_a, .irq_source_b, .intr_event, .sample_valid,
    .tilt_sample, .z_negative, .z_orient, .position, .tilt35_detect, .intr_flags,
    .irq_pin_a_o, .irq_pin_a_oe_n, .serial_out_pin_bidir);

// ==== sim/itc_config_tb.sv ====
/* Self-checking bench of itc_config driven through the host model.
   Assumes itc_pkg and the bound checker are compiled with it. */
`timescale 1ns/100ps
module itc_config_tb;
    logic clk = 1'b0, rst_n = 1'b0, reg_wr, reg_rd, irq_source_a, irq_source_b;
    logic pin_b_gpio_mode, sample_valid, z_negative, z_orient, tilt35_detect;
    logic irq_pin_a_o, irq_pin_a_oe_n, irq_pin_b_o, irq_pin_b_oe_n;
    logic serial_out_pin_bidir, bitmask_clear_enable;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, intr_event, intr_flags, rv;
    logic [15:0] tilt_sample;
    logic [1:0] position;
    int n_mismatch = 0;
    int total_checks = 0;
    always #10 clk = ~clk;
    itc_config dut (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .irq_source_a, .irq_source_b, .intr_event, .pin_b_gpio_mode, .sample_valid,
        .tilt_sample, .z_negative, .z_orient, .position, .tilt35_detect, .intr_flags,
        .irq_pin_a_o, .irq_pin_a_oe_n, .irq_pin_b_o, .irq_pin_b_oe_n,
        .serial_out_pin_bidir, .bitmask_clear_enable);
    itc_host_model host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic smp(input logic [15:0] s, input logic zn);
        @(posedge clk);
        sample_valid <= 1'b1;
        tilt_sample  <= s;
        z_negative   <= zn;
        @(posedge clk);
        sample_valid <= 1'b0;
        #1;
    endtask : smp
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        {irq_source_a, irq_source_b, pin_b_gpio_mode, sample_valid, z_negative, z_orient} = 6'h0;
        {intr_event, tilt_sample} = 24'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        host.rd(8'h31, rv);
        chk(rv, 8'h00);
        host.rd(8'h33, rv);
        chk(rv, 8'h00);
        host.wr(8'h31, 8'hff);
        host.rd(8'h31, rv);
        chk(rv, 8'h70);
        chk({6'h0, serial_out_pin_bidir, bitmask_clear_enable}, 8'h03);
        host.wr(8'h33, 8'hcc);
        @(posedge clk);
        irq_source_a <= 1'b1;
        tick(3);
        chk({4'h0, irq_pin_a_o, irq_pin_b_o, irq_pin_a_oe_n, irq_pin_b_oe_n}, 8'h04);
        host.wr(8'h33, 8'h00);
        tick(3);
        chk({6'h0, irq_pin_a_oe_n, irq_pin_b_oe_n}, 8'h02);
        host.wr(8'h31, 8'h40);
        @(posedge clk);
        intr_event <= 8'hff;
        @(posedge clk);
        intr_event <= 8'h00;
        tick(2);
        chk({6'h0, irq_pin_a_oe_n, irq_pin_b_oe_n}, 8'h01);
        host.wr(8'h14, 8'h0f);
        tick(1);
        chk(intr_flags, 8'hf0);
        host.wr(8'h31, 8'h00);
        host.wr(8'h14, 8'h01);
        tick(1);
        chk(intr_flags, 8'h00);
        host.wr(8'h40, 8'h00);
        host.wr(8'h41, 8'h81);
        smp(16'hfeff, 1'b0);
        chk({4'h0, tilt35_detect, intr_flags[4], position}, 8'h0d);
        smp(16'h00ff, 1'b1);
        chk({5'h0, tilt35_detect, position}, 8'h02);
        smp(16'hff01, 1'b0);
        chk({5'h0, tilt35_detect, position}, 8'h00);
        z_orient <= 1'b1;
        smp(16'h00ff, 1'b0);
        chk({5'h0, tilt35_detect, position}, 8'h02);
        smp(16'h0100, 1'b1);
        chk({5'h0, tilt35_detect, position}, 8'h02);
        host.wr(8'h33, 8'h80);
        pin_b_gpio_mode <= 1'b1;
        tick(2);
        chk({6'h0, irq_pin_b_o, irq_pin_b_oe_n}, 8'h00);
        host.wr(8'h33, 8'hc0);
        tick(2);
        chk({6'h0, irq_pin_b_o, irq_pin_b_oe_n}, 8'h02);
        wrap_up();
    end
    initial begin
        repeat (2000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end
endmodule : itc_config_tb

// ==== sim/itc_host_model.sv ====
/* Host side of the register bus, driven by the bench through its tasks.
   Assumes one-cycle strobes taken on the rising edge of clk. */
`timescale 1ns/100ps
module itc_host_model (
    // Clock
    input  wire logic       clk,
    // Register bus
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= (a == 8'h31) ? (d & 8'h73) : d;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
endmodule : itc_host_model
